//--- verilog/seq_consts.svh
// Offsets, field positions, reset values and sizes of the feature set sequencer.
// Assumes a 32-bit word register port with byte addresses.
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH

`define SEQ_SET_COUNT 16
`define SEQ_SET_BITS 4
`define SEQ_FEATURE_COUNT 7
`define SEQ_PATH_COUNT 2
`define SEQ_EVENT_COUNT 4

`define SEQ_OFF_CTRL 8'h00
`define SEQ_OFF_FEAT_SEL 8'h04
`define SEQ_OFF_FEAT_EN 8'h08
`define SEQ_OFF_SET_SEL 8'h0C
`define SEQ_OFF_CMD 8'h10
`define SEQ_OFF_ACTIVE 8'h14
`define SEQ_OFF_START 8'h18
`define SEQ_OFF_PATH_SEL 8'h1C
`define SEQ_OFF_NEXT 8'h20
`define SEQ_OFF_TRIG_SRC 8'h24
`define SEQ_OFF_TRIG_EDGE 8'h28
`define SEQ_OFF_LIVE_BASE 8'h40

`define SEQ_CTRL_RUN_BIT 0
`define SEQ_CTRL_CONFIG_BIT 1
`define SEQ_CMD_SAVE_BIT 0
`define SEQ_CMD_LOAD_BIT 1
`define SEQ_EDGE_RISING 32'h0000_0000

`define SEQ_STORE_GLOBAL_BIT 7
`define SEQ_STORE_PATH_WORD 3'h7

`define SEQ_RST_WORD 32'h0000_0000
`define SEQ_RST_SET 4'h0
`define SEQ_RST_FEAT_EN 7'h00

`endif

//--- verilog/seq_pkg.sv
// Types shared by the feature set sequencer modules.
// Assumes seq_consts.svh is on the include path.
package seq_pkg;
    `include "seq_consts.svh"

    typedef enum logic [2:0] {
        SRC_OFF = 3'h0,
        SRC_EXPOSURE = 3'h1,
        SRC_COUNTER_ZERO = 3'h2,
        SRC_TIMER_ZERO = 3'h3,
        SRC_ENCODER = 3'h4
    } trig_src_t;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'h0,
        SEQ_START = 2'h1,
        SEQ_RUN = 2'h3
    } seq_state_t;

    typedef struct packed {
        logic [3:0] next_set_index;
        trig_src_t step_trigger_source;
    } path_cfg_t;

    typedef struct packed {
        logic [31:0] lens_optical_power;
        logic [31:0] lens_drive_current;
        logic [31:0] gain;
        logic [31:0] roi_vertical_offset;
        logic [31:0] roi_horizontal_offset;
        logic [31:0] counter_length;
        logic [31:0] exposure_time;
    } sensor_settings_t;

    typedef logic [`SEQ_FEATURE_COUNT-1:0][31:0] feature_words_t;
endpackage

//--- verilog/step_trigger_detect.sv
// Rising-edge detector for one branch path's step trigger source.
// Assumes the event inputs come from logic on sys_clk.
`include "seq_consts.svh"
module step_trigger_detect
    import seq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire trig_src_t source,
    input wire logic [`SEQ_EVENT_COUNT-1:0] events,
    output logic fire
);
    logic [`SEQ_EVENT_COUNT-1:0] prev;
    logic [`SEQ_EVENT_COUNT-1:0] next_prev;
    logic [`SEQ_EVENT_COUNT-1:0] rising;

    always_comb begin
        next_prev = events;
        rising = events & ~prev;
        case (source)
            SRC_EXPOSURE: fire = rising[0];
            SRC_COUNTER_ZERO: fire = rising[1];
            SRC_TIMER_ZERO: fire = rising[2];
            SRC_ENCODER: fire = rising[3];
            default: fire = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prev <= '0;
        end else begin
            prev <= next_prev;
        end
    end

    chk_off_never_fires: assert property (@(posedge sys_clk) disable iff (rst)
        source == SRC_OFF |-> !fire)
        else $error("Disabled trigger source produced a step.");
endmodule // step_trigger_detect

//--- verilog/feature_set_sequencer.sv
// Camera acquisition sequencer: sixteen stored setting sets with branch paths.
// Assumes the register port and trigger events share sys_clk.
//
// Our own choices: the address map and the plain strobed port.
`include "seq_consts.svh"
module feature_set_sequencer
    import seq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic exposure_done,
    input wire logic counter_zero_done,
    input wire logic timer_zero_done,
    input wire logic encoder_out,
    input wire logic [7:0] store_addr,
    input wire logic store_wr,
    input wire logic [31:0] store_wdata,
    input wire logic store_rd,
    output logic [31:0] store_rdata,
    output sensor_settings_t live_settings,
    output logic [3:0] active_set_index,
    output logic seq_running
);
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        return addr == off;
    endfunction

    feature_words_t set_mem [`SEQ_SET_COUNT];
    path_cfg_t path_mem [`SEQ_SET_COUNT][`SEQ_PATH_COUNT];

    seq_state_t state, next_state;
    feature_words_t live, next_live;
    logic seq_run_enable, next_seq_run_enable;
    logic seq_config_mode, next_seq_config_mode;
    logic [2:0] seq_feature_select, next_seq_feature_select;
    logic [`SEQ_FEATURE_COUNT-1:0] seq_feature_enable, next_seq_feature_enable;
    logic [3:0] set_index_select, next_set_index_select;
    logic [3:0] start_set_index, next_start_set_index;
    logic branch_path_select, next_branch_path_select;
    logic [3:0] next_active_set_index;
    logic [31:0] next_reg_rdata, next_store_rdata;
    logic save_now, load_now, apply_now, path_wr, store_set_wr, store_path_wr;
    logic [3:0] apply_set;
    logic [`SEQ_PATH_COUNT-1:0] fire;
    logic [`SEQ_EVENT_COUNT-1:0] events;
    path_cfg_t path_wdata;

    assign events = {encoder_out, timer_zero_done, counter_zero_done, exposure_done};

    genvar p;
    generate
        for (p = 0; p < `SEQ_PATH_COUNT; p++) begin : g_path
            step_trigger_detect u_detect (
                .sys_clk(sys_clk),
                .rst(rst),
                .source(path_mem[active_set_index][p].step_trigger_source),
                .events(events),
                .fire(fire[p])
            );
        end
    endgenerate

    // Sequencer stepping and the set that is applied to the live settings.
    always_comb begin
        next_state = state;
        next_active_set_index = active_set_index;
        apply_now = 1'b0;
        apply_set = active_set_index;
        case (state)
            SEQ_IDLE: begin
                if (seq_run_enable) begin
                    next_state = SEQ_START;
                end
            end
            SEQ_START: begin
                if (!seq_run_enable) begin
                    next_state = SEQ_IDLE;
                end else begin
                    next_state = SEQ_RUN;
                    next_active_set_index = start_set_index;
                    apply_now = 1'b1;
                    apply_set = start_set_index;
                end
            end
            SEQ_RUN: begin
                if (!seq_run_enable) begin
                    next_state = SEQ_IDLE;
                end else if (fire[0]) begin
                    next_active_set_index = path_mem[active_set_index][0].next_set_index;
                    apply_now = 1'b1;
                    apply_set = next_active_set_index;
                end else if (fire[1]) begin
                    next_active_set_index = path_mem[active_set_index][1].next_set_index;
                    apply_now = 1'b1;
                    apply_set = next_active_set_index;
                end
            end
            default: next_state = SEQ_IDLE;
        endcase
    end

    // Host registers, commands and the live feature values.
    always_comb begin
        next_seq_run_enable = seq_run_enable;
        next_seq_config_mode = seq_config_mode;
        next_seq_feature_select = seq_feature_select;
        next_seq_feature_enable = seq_feature_enable;
        next_set_index_select = set_index_select;
        next_start_set_index = start_set_index;
        next_branch_path_select = branch_path_select;
        next_live = live;
        save_now = 1'b0;
        load_now = 1'b0;
        path_wr = 1'b0;
        path_wdata = path_mem[set_index_select][branch_path_select];
        if (reg_wr) begin
            if (hit(reg_addr, `SEQ_OFF_CTRL)) begin
                next_seq_run_enable = reg_wdata[`SEQ_CTRL_RUN_BIT];
                next_seq_config_mode = reg_wdata[`SEQ_CTRL_CONFIG_BIT];
            end
            if (hit(reg_addr, `SEQ_OFF_FEAT_SEL)) begin
                next_seq_feature_select = reg_wdata[2:0];
            end
            if (hit(reg_addr, `SEQ_OFF_FEAT_EN) && seq_feature_select < 3'h7) begin
                next_seq_feature_enable[seq_feature_select] = reg_wdata[0];
            end
            if (hit(reg_addr, `SEQ_OFF_SET_SEL)) begin
                next_set_index_select = reg_wdata[3:0];
            end
            if (hit(reg_addr, `SEQ_OFF_START)) begin
                next_start_set_index = reg_wdata[3:0];
            end
            if (hit(reg_addr, `SEQ_OFF_PATH_SEL)) begin
                next_branch_path_select = reg_wdata[0];
            end
            if (hit(reg_addr, `SEQ_OFF_CMD)) begin
                save_now = reg_wdata[`SEQ_CMD_SAVE_BIT] && seq_config_mode;
                load_now = reg_wdata[`SEQ_CMD_LOAD_BIT];
            end
            if (hit(reg_addr, `SEQ_OFF_NEXT) && seq_config_mode) begin
                path_wr = 1'b1;
                path_wdata.next_set_index = reg_wdata[3:0];
            end
            if (hit(reg_addr, `SEQ_OFF_TRIG_SRC) && seq_config_mode) begin
                path_wr = 1'b1;
                path_wdata.step_trigger_source = trig_src_t'(reg_wdata[2:0]);
            end
            for (int k = 0; k < `SEQ_FEATURE_COUNT; k++) begin
                if (hit(reg_addr, 8'(`SEQ_OFF_LIVE_BASE + 4 * k))) begin
                    next_live[k] = reg_wdata;
                end
            end
        end
        if (store_wr && store_addr[`SEQ_STORE_GLOBAL_BIT]) begin
            next_seq_feature_enable = store_wdata[6:0];
            next_start_set_index = store_wdata[10:7];
        end
        // A sequencer step takes precedence over a host load in the same cycle.
        for (int k = 0; k < `SEQ_FEATURE_COUNT; k++) begin
            if (seq_feature_enable[k]) begin
                if (apply_now) begin
                    next_live[k] = set_mem[apply_set][k];
                end else if (load_now) begin
                    next_live[k] = set_mem[set_index_select][k];
                end
            end
        end
    end

    // Register read data, valid in the cycle after the read strobe.
    always_comb begin
        next_reg_rdata = 32'h0000_0000;
        if (reg_rd) begin
            for (int k = 0; k < `SEQ_FEATURE_COUNT; k++) begin
                if (hit(reg_addr, 8'(`SEQ_OFF_LIVE_BASE + 4 * k))) begin
                    next_reg_rdata = live[k];
                end
            end
            case (reg_addr)
                `SEQ_OFF_CTRL: next_reg_rdata = {30'h0, seq_config_mode, seq_run_enable};
                `SEQ_OFF_FEAT_SEL: next_reg_rdata = {29'h0, seq_feature_select};
                `SEQ_OFF_FEAT_EN: next_reg_rdata = {31'h0,
                    seq_feature_select < 3'h7 && seq_feature_enable[seq_feature_select]};
                `SEQ_OFF_SET_SEL: next_reg_rdata = {28'h0, set_index_select};
                `SEQ_OFF_ACTIVE: next_reg_rdata = {28'h0, active_set_index};
                `SEQ_OFF_START: next_reg_rdata = {28'h0, start_set_index};
                `SEQ_OFF_PATH_SEL: next_reg_rdata = {31'h0, branch_path_select};
                `SEQ_OFF_NEXT: next_reg_rdata = {28'h0,
                    path_mem[set_index_select][branch_path_select].next_set_index};
                `SEQ_OFF_TRIG_SRC: next_reg_rdata = {29'h0,
                    path_mem[set_index_select][branch_path_select].step_trigger_source};
                `SEQ_OFF_TRIG_EDGE: next_reg_rdata = `SEQ_EDGE_RISING;
                default: ;
            endcase
        end
    end

    // User-set persistence port: per-set words, path word, and one global word.
    always_comb begin
        store_set_wr = store_wr && !store_addr[`SEQ_STORE_GLOBAL_BIT]
            && store_addr[2:0] != `SEQ_STORE_PATH_WORD;
        store_path_wr = store_wr && !store_addr[`SEQ_STORE_GLOBAL_BIT]
            && store_addr[2:0] == `SEQ_STORE_PATH_WORD;
        next_store_rdata = 32'h0000_0000;
        if (store_rd) begin
            if (store_addr[`SEQ_STORE_GLOBAL_BIT]) begin
                next_store_rdata = {21'h0, start_set_index, seq_feature_enable};
            end else if (store_addr[2:0] == `SEQ_STORE_PATH_WORD) begin
                next_store_rdata = {18'h0, path_mem[store_addr[6:3]][1],
                    path_mem[store_addr[6:3]][0]};
            end else begin
                next_store_rdata = set_mem[store_addr[6:3]][store_addr[2:0]];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= SEQ_IDLE;
            live <= '0;
            seq_run_enable <= 1'b0;
            seq_config_mode <= 1'b0;
            seq_feature_select <= 3'h0;
            seq_feature_enable <= `SEQ_RST_FEAT_EN;
            set_index_select <= `SEQ_RST_SET;
            start_set_index <= `SEQ_RST_SET;
            branch_path_select <= 1'b0;
            active_set_index <= `SEQ_RST_SET;
            reg_rdata <= `SEQ_RST_WORD;
            store_rdata <= `SEQ_RST_WORD;
        end else begin
            state <= next_state;
            live <= next_live;
            seq_run_enable <= next_seq_run_enable;
            seq_config_mode <= next_seq_config_mode;
            seq_feature_select <= next_seq_feature_select;
            seq_feature_enable <= next_seq_feature_enable;
            set_index_select <= next_set_index_select;
            start_set_index <= next_start_set_index;
            branch_path_select <= next_branch_path_select;
            active_set_index <= next_active_set_index;
            reg_rdata <= next_reg_rdata;
            store_rdata <= next_store_rdata;
        end
    end

    // Set memories; a save command wins over a persistence write to the same set.
    always_ff @(posedge sys_clk) begin
        if (store_set_wr) begin
            set_mem[store_addr[6:3]][store_addr[2:0]] <= store_wdata;
        end
        if (store_path_wr) begin
            path_mem[store_addr[6:3]][0] <= path_cfg_t'(store_wdata[6:0]);
            path_mem[store_addr[6:3]][1] <= path_cfg_t'(store_wdata[13:7]);
        end
        if (path_wr) begin
            path_mem[set_index_select][branch_path_select] <= path_wdata;
        end
        for (int k = 0; k < `SEQ_FEATURE_COUNT; k++) begin
            if (save_now && seq_feature_enable[k]) begin
                set_mem[set_index_select][k] <= live[k];
            end
        end
    end

    assign live_settings = sensor_settings_t'(live);
    assign seq_running = state == SEQ_RUN;

    chk_save_copies_live: assert property (@(posedge sys_clk) disable iff (rst)
        save_now && seq_feature_enable[0] |=>
        set_mem[$past(set_index_select)][0] == $past(live[0]))
        else $error("Save did not copy the live exposure value.");

    chk_load_applies_set: assert property (@(posedge sys_clk) disable iff (rst)
        load_now && !apply_now && seq_feature_enable[1] |=>
        live[1] == $past(set_mem[set_index_select][1]))
        else $error("Load did not apply the selected set.");

    chk_path0_step: assert property (@(posedge sys_clk) disable iff (rst)
        state == SEQ_RUN && seq_run_enable && fire[0] |=>
        active_set_index == $past(path_mem[active_set_index][0].next_set_index))
        else $error("Path zero trigger did not reach its next set.");

    chk_path_priority: assert property (@(posedge sys_clk) disable iff (rst)
        state == SEQ_RUN && seq_run_enable && fire[0] && fire[1] |=>
        active_set_index == $past(path_mem[active_set_index][0].next_set_index))
        else $error("Lower path did not win a simultaneous trigger.");

    chk_start_set: assert property (@(posedge sys_clk) disable iff (rst)
        state == SEQ_IDLE ##1 seq_run_enable && state == SEQ_START |=>
        active_set_index == $past(start_set_index) && seq_running)
        else $error("Sequencing did not begin at the start set.");

    chk_idle_holds: assert property (@(posedge sys_clk) disable iff (rst)
        state == SEQ_IDLE |=> $stable(active_set_index))
        else $error("Active set changed while the sequencer was off.");

    chk_active_readback: assert property (@(posedge sys_clk) disable iff (rst)
        reg_rd && reg_addr == `SEQ_OFF_ACTIVE |=> reg_rdata == {28'h0, $past(active_set_index)})
        else $error("Active set readback mismatch.");

    chk_edge_fixed: assert property (@(posedge sys_clk) disable iff (rst)
        reg_rd && reg_addr == `SEQ_OFF_TRIG_EDGE |=> reg_rdata == `SEQ_EDGE_RISING)
        else $error("Trigger activation did not read as rising edge.");

    chk_save_needs_config: assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == `SEQ_OFF_CMD && reg_wdata[`SEQ_CMD_SAVE_BIT]
        && !seq_config_mode && !store_wr |=>
        set_mem[$past(set_index_select)][0] == $past(set_mem[set_index_select][0]))
        else $error("Save accepted outside configuration mode.");
endmodule // feature_set_sequencer

//--- bench/feature_set_sequencer_tb_top.sv
// Self-checking testbench for the feature set sequencer.
// Assumes seq_pkg and seq_consts.svh are compiled first; drives every port itself.
`include "seq_consts.svh"
module feature_set_sequencer_tb_top
    import seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rst, reg_wr, reg_rd, store_wr, store_rd, seq_running;
    logic [7:0] reg_addr, store_addr;
    logic [31:0] reg_wdata, reg_rdata, store_wdata, store_rdata, rd_val;
    logic [3:0] ev, active_set_index;
    sensor_settings_t live_settings;
    logic [223:0] live_flat;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    assign live_flat = live_settings;
    feature_set_sequencer dut (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .exposure_done(ev[0]), .counter_zero_done(ev[1]), .timer_zero_done(ev[2]),
        .encoder_out(ev[3]), .store_addr(store_addr), .store_wr(store_wr),
        .store_wdata(store_wdata), .store_rd(store_rd), .store_rdata(store_rdata),
        .live_settings(live_settings), .active_set_index(active_set_index),
        .seq_running(seq_running)
    );
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic give_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        chk(reg_rdata, exp);
    endtask
    task automatic st_access(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        store_wr <= w;
        store_rd <= ~w;
        store_addr <= a;
        store_wdata <= d;
        @(posedge sys_clk);
        store_wr <= 1'b0;
        store_rd <= 1'b0;
        @(negedge sys_clk);
    endtask
    function automatic logic [31:0] val(input int s, input int k);
        return 32'hA000_0000 + 32'(s * 256 + k);
    endfunction
    task automatic chk_live(input int s);
        for (int k = 0; k < 7; k++) begin
            chk(live_flat[k*32 +: 32], val(s, k));
        end
    endtask
    task automatic fill_set(input int s);
        wr(`SEQ_OFF_SET_SEL, 32'(s));
        for (int k = 0; k < 7; k++) begin
            wr(8'(`SEQ_OFF_LIVE_BASE + 4 * k), val(s, k));
        end
        wr(`SEQ_OFF_CMD, 32'h0000_0001);
    endtask
    task automatic set_path(input int s, input int p, input int nxt, input int src);
        wr(`SEQ_OFF_SET_SEL, 32'(s));
        wr(`SEQ_OFF_PATH_SEL, 32'(p));
        wr(`SEQ_OFF_NEXT, 32'(nxt));
        wr(`SEQ_OFF_TRIG_SRC, 32'(src));
    endtask
    // Raises the given events, checks the step, then checks a held level does not step again.
    task automatic step(input logic [3:0] mask, input logic [3:0] exp);
        @(posedge sys_clk);
        ev <= mask;
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk({28'h0, active_set_index}, {28'h0, exp});
        @(negedge sys_clk);
        chk({28'h0, active_set_index}, {28'h0, exp});
        @(posedge sys_clk);
        ev <= 4'h0;
    endtask
    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        store_wr = 1'b0;
        store_rd = 1'b0;
        store_addr = 8'h00;
        store_wdata = 32'h0000_0000;
        ev = 4'h0;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        rd_chk(`SEQ_OFF_CTRL, 32'h0000_0000);
        rd_chk(`SEQ_OFF_ACTIVE, 32'h0000_0000);
        rd_chk(8'h3C, 32'h0000_0000);
        chk({31'h0, seq_running}, 32'h0000_0000);
        $display("test reset done");
        wr(`SEQ_OFF_TRIG_EDGE, 32'h0000_0001);
        rd_chk(`SEQ_OFF_TRIG_EDGE, `SEQ_EDGE_RISING);
        $display("test edge fixed done");
        wr(`SEQ_OFF_CTRL, 32'h0000_0002);
        for (int k = 0; k < 7; k++) begin
            wr(`SEQ_OFF_FEAT_SEL, 32'(k));
            wr(`SEQ_OFF_FEAT_EN, 32'h0000_0001);
        end
        wr(`SEQ_OFF_FEAT_SEL, 32'h0000_0003);
        rd_chk(`SEQ_OFF_FEAT_EN, 32'h0000_0001);
        fill_set(0);
        fill_set(1);
        fill_set(2);
        fill_set(15);
        set_path(0, 0, 1, 1);
        set_path(0, 1, 2, 2);
        set_path(1, 0, 2, 0);
        set_path(1, 1, 0, 4);
        set_path(2, 0, 15, 3);
        set_path(2, 1, 1, 0);
        set_path(15, 0, 0, 0);
        set_path(15, 1, 1, 5);
        rd_chk(`SEQ_OFF_TRIG_SRC, 32'h0000_0005);
        $display("test program done");
        wr(`SEQ_OFF_SET_SEL, 32'h0000_0002);
        wr(`SEQ_OFF_CMD, 32'h0000_0002);
        @(negedge sys_clk);
        chk_live(2);
        $display("test load done");
        st_access(1'b0, 8'h07, 32'h0000_0000);
        chk(store_rdata, 32'h0000_0909);
        st_access(1'b0, 8'h80, 32'h0000_0000);
        chk(store_rdata, 32'h0000_007F);
        st_access(1'b1, 8'h10, 32'hCAFE_0001);
        wr(`SEQ_OFF_SET_SEL, 32'h0000_0002);
        wr(`SEQ_OFF_CMD, 32'h0000_0002);
        @(negedge sys_clk);
        chk(live_flat[31:0], 32'hCAFE_0001);
        st_access(1'b1, 8'h80, 32'h0000_017F);
        rd_chk(`SEQ_OFF_START, 32'h0000_0002);
        st_access(1'b1, 8'h2F, 32'h0000_0909);
        st_access(1'b0, 8'h2F, 32'h0000_0000);
        chk(store_rdata, 32'h0000_0909);
        $display("test persistence done");
        wr(`SEQ_OFF_START, 32'h0000_0000);
        wr(`SEQ_OFF_CTRL, 32'h0000_0003);
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk({31'h0, seq_running}, 32'h0000_0001);
        chk({28'h0, active_set_index}, 32'h0000_0000);
        chk_live(0);
        step(4'b0011, 4'h1);
        chk_live(1);
        step(4'b1000, 4'h0);
        step(4'b0010, 4'h2);
        step(4'b0100, 4'hF);
        chk_live(15);
        step(4'b1111, 4'hF);
        rd_chk(`SEQ_OFF_ACTIVE, 32'h0000_000F);
        $display("test run done");
        wr(`SEQ_OFF_CTRL, 32'h0000_0000);
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk({31'h0, seq_running}, 32'h0000_0000);
        wr(`SEQ_OFF_LIVE_BASE, 32'h1234_5678);
        wr(`SEQ_OFF_SET_SEL, 32'h0000_000F);
        wr(`SEQ_OFF_CMD, 32'h0000_0001);
        wr(`SEQ_OFF_CMD, 32'h0000_0002);
        @(negedge sys_clk);
        chk(live_flat[31:0], val(15, 0));
        $display("test stop done");
        give_verdict();
    end
endmodule // feature_set_sequencer_tb_top
